// ---- src/ifepb_cfg.svh ----
// register map, field layout and reset values of the interrupt bank
// assumes nothing beyond a 32-bit apb data path
`ifndef IFEPB_CFG_SVH
`define IFEPB_CFG_SVH

`define IFEPB_ADDR_W 12
`define IFEPB_FLAG_OFF 12'h000
`define IFEPB_FLAG_SET_OFF 12'h004
`define IFEPB_FLAG_CLR_OFF 12'h008
`define IFEPB_EN_OFF 12'h010
`define IFEPB_PRIO_BASE 12'h020
`define IFEPB_PRIO_LAST 12'h03c
`define IFEPB_SEL_OFF 12'h040
`define IFEPB_WORD_RST 32'h00000000
`define IFEPB_PRIO_LSB 2
`define IFEPB_PRIO_W 3
`define IFEPB_SUB_W 2
`define IFEPB_LANE_W 8
`define IFEPB_SRC_PER_WORD 4
`define IFEPB_PRIO_OFF 3'h0

`endif

// ---- src/ifepb_pkg.sv ----
// types shared by the interrupt bank modules
// assumes ifepb_cfg.svh is on the include path
`include "ifepb_cfg.svh"

package ifepb_pkg;
	typedef logic [`IFEPB_PRIO_W-1:0] ifepb_prio_t;
	typedef logic [`IFEPB_SUB_W-1:0] ifepb_sub_t;
	typedef enum logic [1:0] {
		IFEPB_IDLE,
		IFEPB_ACCESS
	} ifepb_apb_t;
endpackage : ifepb_pkg

// ---- src/ifepb_select.sv ----
// picks the winning pending source by priority, subpriority, index
// assumes a packed priority and subpriority per source
`timescale 1ns/100ps
`default_nettype none

module ifepb_select
	import ifepb_pkg::*;
#(
	parameter int N = 32
) (
	input wire logic [N-1:0] pend, // flag and enable per source
	input wire logic [N*3-1:0] prio, // priority per source
	input wire logic [N*2-1:0] sub, // subpriority per source
	output logic valid, // some source presented
	output logic [4:0] idx, // winning source
	output logic [2:0] level, // winning priority
	output logic [1:0] level_sub // winning subpriority
);
	always_comb begin
		valid = 1'b0;
		idx = 5'h00;
		level = 3'h0;
		level_sub = 2'h0;
		for (int i = 0; i < N; i++) begin
			// zero priority never wins
			if (pend[i] && prio[i*3 +: 3] != 3'h0 && (!valid ||
				{prio[i*3 +: 3], sub[i*2 +: 2]} > {level, level_sub})) begin
				valid = 1'b1;
				idx = 5'(i);
				level = prio[i*3 +: 3];
				level_sub = sub[i*2 +: 2];
			end
		end
	end
endmodule : ifepb_select

`default_nettype wire

// ---- src/ifepb_sync.sv ----
// two flip-flop synchroniser for a bank of request lines
// assumes inputs come from another clock domain or pins
`timescale 1ns/100ps
`default_nettype none

module ifepb_sync #(
	parameter int W = 32
) (
	input wire logic clock, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic [W-1:0] async, // raw request lines
	output logic [W-1:0] sync // synchronised lines
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async;
			sync_ff <= meta_ff;
		end
	end
	assign sync = sync_ff;
endmodule : ifepb_sync

`default_nettype wire

// ---- src/irq_flag_enable_priority_bank.sv ----
// interrupt flag, enable and priority bank behind an apb slave
// assumes one 10 MHz clock; request lines may come from pins
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none

module irq_flag_enable_priority_bank
	import ifepb_pkg::*;
#(
	parameter int NSRC = 32
) (
	input wire logic clock, // system clock, 10 MHz
	input wire logic rst_b, // async reset, active low
	input wire logic [NSRC-1:0] srcReq, // peripheral request lines
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [`IFEPB_ADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address or write to the winner word
	output logic irqValid, // a source is presented to the core
	output logic [4:0] irqIndex, // presented source
	output logic [2:0] irqLevel, // its priority
	output logic [1:0] irqSubLevel // its subpriority
);
	localparam int NPW = NSRC / `IFEPB_SRC_PER_WORD;

	logic [NSRC-1:0] reqSync;
	logic [NSRC-1:0] reqPrev_ff, nxt_reqPrev;
	logic [NSRC-1:0] flag_ff, nxt_flag;
	logic [NSRC-1:0] enable_ff, nxt_enable;
	logic [31:0] prio_ff [NPW];
	logic [31:0] nxt_prio [NPW];
	logic [31:0] rdata_ff, nxt_rdata;
	logic err_ff, nxt_err;
	ifepb_apb_t state_ff, nxt_state;
	logic irqValid_ff, nxt_irqValid;
	logic [4:0] irqIndex_ff, nxt_irqIndex;
	logic [2:0] irqLevel_ff, nxt_irqLevel;
	logic [1:0] irqSub_ff, nxt_irqSub;
	logic [NSRC*3-1:0] prioVec;
	logic [NSRC*2-1:0] subVec;
	logic selValid;
	logic [4:0] selIdx;
	logic [2:0] selLevel;
	logic [1:0] selSub;
	logic setup, wrEn, rdEn;
	logic [31:0] wmask;

	// byte strobes to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{s[b]}};
		end
		return m;
	endfunction : lane_mask

	// keeps only the implemented five bits of each lane
	function automatic logic [31:0] prio_keep(input logic [31:0] v);
		logic [31:0] r;
		r = '0;
		for (int b = 0; b < `IFEPB_SRC_PER_WORD; b++) begin
			r[b*`IFEPB_LANE_W +: 5] = v[b*`IFEPB_LANE_W +: 5];
		end
		return r;
	endfunction : prio_keep

	// address hits a priority word
	function automatic logic is_prio(input logic [`IFEPB_ADDR_W-1:0] a);
		return a >= `IFEPB_PRIO_BASE && a <= `IFEPB_PRIO_LAST &&
			a[1:0] == 2'h0;
	endfunction : is_prio

	ifepb_sync #(.W(NSRC)) u_sync (
		.clock(clock),
		.rst_b(rst_b),
		.async(srcReq),
		.sync(reqSync)
	);

	// flatten priority words into per-source fields
	generate
		for (genvar s = 0; s < NSRC; s++) begin : g_fields
			localparam int LANE = (s % `IFEPB_SRC_PER_WORD) * `IFEPB_LANE_W;
			assign prioVec[s*3 +: 3] =
				prio_ff[s / `IFEPB_SRC_PER_WORD][LANE+`IFEPB_PRIO_LSB +: 3];
			assign subVec[s*2 +: 2] =
				prio_ff[s / `IFEPB_SRC_PER_WORD][LANE +: 2];
		end
	endgenerate

	ifepb_select #(.N(NSRC)) u_select (
		.pend(flag_ff & enable_ff),
		.prio(prioVec),
		.sub(subVec),
		.valid(selValid),
		.idx(selIdx),
		.level(selLevel),
		.level_sub(selSub)
	);

	assign setup = psel && !penable;
	assign wrEn = psel && penable && pwrite && state_ff == IFEPB_ACCESS;
	assign rdEn = setup && !pwrite;
	assign wmask = lane_mask(pstrb);

	// apb phase tracking: zero wait states
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			IFEPB_IDLE: begin
				if (setup) begin
					nxt_state = IFEPB_ACCESS;
				end
			end
			IFEPB_ACCESS: begin
				nxt_state = setup ? IFEPB_ACCESS : IFEPB_IDLE;
			end
		endcase
	end

	// flags: rising request sets, set beats software clear
	always_comb begin
		nxt_reqPrev = reqSync;
		nxt_flag = flag_ff;
		if (wrEn) begin
			unique case (paddr)
				`IFEPB_FLAG_OFF: nxt_flag = (flag_ff & ~wmask) |
					(pwdata & wmask);
				`IFEPB_FLAG_SET_OFF: nxt_flag = flag_ff | (pwdata & wmask);
				`IFEPB_FLAG_CLR_OFF: nxt_flag = flag_ff & ~(pwdata & wmask);
				default: nxt_flag = flag_ff;
			endcase
		end
		nxt_flag = nxt_flag | (reqSync & ~reqPrev_ff);
	end

	// enables and priority words
	always_comb begin
		nxt_enable = enable_ff;
		for (int w = 0; w < NPW; w++) begin
			nxt_prio[w] = prio_ff[w];
		end
		if (wrEn && paddr == `IFEPB_EN_OFF) begin
			nxt_enable = (enable_ff & ~wmask) | (pwdata & wmask);
		end
		for (int w = 0; w < NPW; w++) begin
			if (wrEn && paddr == `IFEPB_PRIO_BASE + `IFEPB_ADDR_W'(w*4)) begin
				nxt_prio[w] = prio_keep((prio_ff[w] & ~wmask) |
					(pwdata & wmask));
			end
		end
	end

	// read data and error captured in setup, shown in access
	always_comb begin
		nxt_rdata = rdata_ff;
		nxt_err = err_ff;
		if (setup) begin
			nxt_rdata = 32'h00000000;
			nxt_err = 1'b0;
			if (paddr == `IFEPB_FLAG_OFF || paddr == `IFEPB_FLAG_SET_OFF ||
				paddr == `IFEPB_FLAG_CLR_OFF) begin
				nxt_rdata = rdEn ? flag_ff : 32'h00000000;
			end else if (paddr == `IFEPB_EN_OFF) begin
				nxt_rdata = rdEn ? enable_ff : 32'h00000000;
			end else if (is_prio(paddr)) begin
				// base sits on a 32-byte boundary, so bits 4..2 pick the word
				nxt_rdata = rdEn ? prio_keep(prio_ff[paddr[4:2]]) :
					32'h00000000;
			end else if (paddr == `IFEPB_SEL_OFF) begin
				nxt_rdata = rdEn ? {21'h000000, irqValid_ff, irqLevel_ff,
					irqSub_ff, irqIndex_ff} : 32'h00000000;
				nxt_err = pwrite;
			end else begin
				nxt_err = 1'b1;
			end
		end
	end

	// registered winner toward the core
	always_comb begin
		nxt_irqValid = selValid;
		nxt_irqIndex = selValid ? selIdx : 5'h00;
		nxt_irqLevel = selValid ? selLevel : `IFEPB_PRIO_OFF;
		nxt_irqSub = selValid ? selSub : 2'h0;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= IFEPB_IDLE;
			reqPrev_ff <= '0;
			flag_ff <= '0;
			enable_ff <= '0;
			for (int w = 0; w < NPW; w++) begin
				prio_ff[w] <= `IFEPB_WORD_RST;
			end
			rdata_ff <= `IFEPB_WORD_RST;
			err_ff <= 1'b0;
			irqValid_ff <= 1'b0;
			irqIndex_ff <= 5'h00;
			irqLevel_ff <= 3'h0;
			irqSub_ff <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			reqPrev_ff <= nxt_reqPrev;
			flag_ff <= nxt_flag;
			enable_ff <= nxt_enable;
			for (int w = 0; w < NPW; w++) begin
				prio_ff[w] <= nxt_prio[w];
			end
			rdata_ff <= nxt_rdata;
			err_ff <= nxt_err;
			irqValid_ff <= nxt_irqValid;
			irqIndex_ff <= nxt_irqIndex;
			irqLevel_ff <= nxt_irqLevel;
			irqSub_ff <= nxt_irqSub;
		end
	end

	assign pready = psel && penable;
	assign prdata = rdata_ff;
	assign pslverr = psel && penable && err_ff;
	assign irqValid = irqValid_ff;
	assign irqIndex = irqIndex_ff;
	assign irqLevel = irqLevel_ff;
	assign irqSubLevel = irqSub_ff;
endmodule : irq_flag_enable_priority_bank

`default_nettype wire

// ---- test/ifepb_assertions.sv ----
// checker for the interrupt bank, bound to its top module
// assumes a zero-wait apb slave and registered irq outputs
`timescale 1ns/100ps
`default_nettype none
`include "ifepb_cfg.svh"
module ifepb_assertions #(
	parameter int NSRC = 32
) (
	input wire logic clock, // clock
	input wire logic rst_b, // reset
	input wire logic [NSRC-1:0] srcReq, // requests
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // direction
	input wire logic [`IFEPB_ADDR_W-1:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic [3:0] pstrb, // strobes
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic irqValid, // presented
	input wire logic [4:0] irqIndex, // source
	input wire logic [2:0] irqLevel, // priority
	input wire logic [1:0] irqSubLevel // subpriority
);
	wire acc = psel && penable;
	wire wrAll = acc && pwrite && pwdata == 32'h0 && pstrb == 4'hf;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	chk_ready_access: assert property (acc |-> pready)
		else $error("pready low in access");
	chk_lane_top_zero: assert property (acc && !pwrite &&
		paddr[11:5] == 7'h01 |-> (prdata & 32'he0e0e0e0) == 32'h0)
		else $error("priority lane top bits set");
	chk_winner_read: assert property (acc && !pwrite &&
		paddr == `IFEPB_SEL_OFF |-> prdata == {21'h0, $past(irqValid),
		$past(irqLevel), $past(irqSubLevel), $past(irqIndex)})
		else $error("winner word mismatch");
	chk_enable_off: assert property (wrAll &&
		paddr == `IFEPB_EN_OFF |-> ##2 !irqValid)
		else $error("source kept after enables cleared");
	chk_prio_zero: assert property (wrAll &&
		paddr == `IFEPB_PRIO_BASE |-> ##2 (!irqValid || irqIndex > 5'h03))
		else $error("zero priority source presented");
	chk_level_nonzero: assert property (irqValid |-> irqLevel != 3'h0)
		else $error("presented with level zero");
	chk_idle_zero: assert property (!irqValid |->
		{irqIndex, irqLevel, irqSubLevel} == 10'h000)
		else $error("winner fields set while idle");
	chk_reset_clear: assert property (!$past(rst_b) |->
		!irqValid && prdata == 32'h0)
		else $error("state not cleared by reset");
	cover property (irqValid && irqLevel == 3'h7);
	cover property (acc && pslverr);
	cover property (acc && pwrite);
endmodule : ifepb_assertions
bind irq_flag_enable_priority_bank ifepb_assertions #(.NSRC(NSRC)) chk (
	.clock(clock), .rst_b(rst_b), .srcReq(srcReq), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irqValid(irqValid), .irqIndex(irqIndex), .irqLevel(irqLevel),
	.irqSubLevel(irqSubLevel));
`default_nettype wire

// ---- test/ifepb_core_model.sv ----
// core stand-in: remembers the last source offered to it
// assumes registered, level-held irq outputs of the bank
`timescale 1ns/100ps
`default_nettype none
module ifepb_core_model (
	input wire logic clock, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic irqValid, // request presented
	input wire logic [4:0] irqIndex, // presented source
	output logic [4:0] lastSeen_ff // last source taken
);
	logic [4:0] nxt_lastSeen;
	always_comb begin
		nxt_lastSeen = irqValid ? irqIndex : lastSeen_ff;
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			lastSeen_ff <= 5'h00;
		else
			lastSeen_ff <= nxt_lastSeen;
	end
endmodule : ifepb_core_model
`default_nettype wire

// ---- test/irq_flag_enable_priority_bank_tb.sv ----
// self-checking bench: apb register traffic and request lines
// assumes bank, package, core stand-in and checker compile first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
	miscompares++; $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module irq_flag_enable_priority_bank_tb;
	logic clock = 1'h0;
	logic rst_b = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] srcReq = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irqValid, err;
	logic [4:0] irqIndex, lastSeen;
	logic [2:0] irqLevel;
	logic [1:0] irqSubLevel;
	int miscompares = 0;
	int total_checks = 0;
	always #50 clock = ~clock;
	irq_flag_enable_priority_bank #(.NSRC(32)) uut (.clock(clock),
		.rst_b(rst_b), .srcReq(srcReq), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irqValid(irqValid), .irqIndex(irqIndex), .irqLevel(irqLevel),
		.irqSubLevel(irqSubLevel));
	ifepb_core_model core (.clock(clock), .rst_b(rst_b),
		.irqValid(irqValid), .irqIndex(irqIndex), .lastSeen_ff(lastSeen));
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) begin
			miscompares++;
			tally_and_finish();
		end
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask : xfer
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		`CHK(rd, e)
	endtask : rdchk
	task automatic irq(input logic [10:0] e);
		@(negedge clock);
		`CHK({irqValid, irqIndex, irqLevel, irqSubLevel}, e)
		@(posedge clock);
	endtask : irq
	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (3000) @(posedge clock);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		repeat (3) @(posedge clock);
		rst_b <= 1'h1;
		@(posedge clock);
		rdchk(12'h010, 32'h0);
		for (int i = 0; i < 8; i++) rdchk(12'h020 + 12'(4 * i), 32'h0);
		xfer(1'h1, 12'h020, 32'hffffffff);
		rdchk(12'h020, 32'h1f1f1f1f);
		pstrb <= 4'h2;
		xfer(1'h1, 12'h010, 32'hffffffff);
		pstrb <= 4'hf;
		rdchk(12'h010, 32'h0000ff00);
		xfer(1'h1, 12'h010, 32'hffffffff);
		xfer(1'h1, 12'h020, 32'h16000000);
		srcReq <= 32'h8;
		repeat (5) @(posedge clock);
		rdchk(12'h000, 32'h8);
		irq({1'h1, 5'h03, 3'h5, 2'h2});
		xfer(1'h1, 12'h020, 32'h16170000);
		srcReq <= 32'hc;
		repeat (5) @(posedge clock);
		irq({1'h1, 5'h02, 3'h5, 2'h3});
		xfer(1'h1, 12'h020, 32'h16150000);
		irq({1'h1, 5'h03, 3'h5, 2'h2});
		xfer(1'h1, 12'h020, 32'h16151c00);
		srcReq <= 32'he;
		repeat (5) @(posedge clock);
		irq({1'h1, 5'h01, 3'h7, 2'h0});
		`CHK(lastSeen, 5'h01)
		xfer(1'h1, 12'h020, 32'h0);
		irq(11'h000);
		rdchk(12'h000, 32'he);
		xfer(1'h1, 12'h020, 32'h1c000000);
		xfer(1'h1, 12'h010, 32'h0);
		irq(11'h000);
		xfer(1'h1, 12'h010, 32'hffffffff);
		irq({1'h1, 5'h03, 3'h7, 2'h0});
		rdchk(12'h040, {21'h0, 1'h1, 3'h7, 2'h0, 5'h03});
		xfer(1'h1, 12'h000, 32'h80000000);
		rdchk(12'h000, 32'h80000000);
		irq(11'h000);
		rdchk(12'h00c, 32'h0);
		`CHK(err, 1'h1)
		xfer(1'h1, 12'h040, 32'h0);
		`CHK(err, 1'h1)
		tally_and_finish();
	end
endmodule
`default_nettype wire
